// ==== logic/flash_self_access_pkg.sv ====
// Package with register map, field layouts and config space map
package flash_self_access_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_DATA_LOW = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_DATA_HIGH = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ADDR_LOW = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ADDR_HIGH = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h10;
  localparam int WORD_W = 14;
  localparam int PADDR_W = 15;
  localparam int DATA_HIGH_W = 6;
  localparam int ADDR_HIGH_W = 7;
  localparam int CTRL_RD_BIT = 0;
  localparam int CTRL_WR_BIT = 1;
  localparam int CTRL_CONFIG_SPACE_SELECT_BIT = 6;
  localparam logic ADDR_HIGH_TOP = 1'b1;
  localparam logic [7:0] ADDR_LOW_RESET = 8'h00;
  localparam logic [6:0] ADDR_HIGH_RESET = 7'h00;
  localparam logic [7:0] DATA_LOW_RESET = 8'h00;
  localparam logic [5:0] DATA_HIGH_RESET = 6'h00;
  localparam int CFG_ENTRIES = 9;
  localparam logic [3:0] USER_ID_LAST = 4'h3;
  localparam logic [3:0] DEV_ID_IDX = 4'h6;
  localparam logic [3:0] CFG_WORD_FIRST = 4'h7;
  localparam logic [3:0] CFG_WORD_LAST = 4'h8;
  localparam logic [WORD_W-1:0] BLANK_WORD = 14'h3FFF;
  localparam logic [WORD_W-1:0] ZERO_WORD = 14'h0000;
  localparam int PROG_DEPTH = 2048;
  typedef enum logic [1:0] {RESP_OK, RESP_ERR} resp_t;
endpackage

// ==== logic/flash_self_access.sv ====
// Flash self-access register block with config space decode
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// [RULE1] Software changes part of a row by read, modify RAM copy, erase, reload, program.
// [RULE2] With config space select set, accesses go to ID and configuration words.
// [RULE3] The config region is the half with address bit 15 set, only partly mapped.
// [RULE4] A config space read of an unmapped address clears both data registers.
// [RULE5] User IDs 8000h-8003h are RW, 8006h and 8007h-8008h are read only.
// [RULE6] Software verifies the written row against its RAM copy afterwards.
// [RULE7] Data low holds word bits 7:0, RW, unchanged by ordinary reset.
// [RULE8] Data high holds word bits 13:8, top two bits read zero.
// [RULE9] Address low holds address bits 7:0, RW, resets to zero.
// [RULE10] Address high holds address bits 14:8, top bit reads one.
// [RULE11] Writes to read-only config entries leave them unchanged.
module flash_self_access #(
  parameter logic [13:0] DEVICE_ID_WORD = 14'h1234, // Arbitrary value
  parameter logic [13:0] CONFIG_WORD1 = 14'h3FFF,
  parameter logic [13:0] CONFIG_WORD2 = 14'h3FFF
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [flash_self_access_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import flash_self_access_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] dataLow;
  logic [5:0] dataHigh;
  logic [7:0] addrLow;
  logic [6:0] addrHigh;
  logic cfgSel;
  logic ctlWr;
  logic effSel;
  logic [WORD_W-1:0] progMem [PROG_DEPTH];
  logic [WORD_W-1:0] userId [4];
  logic [7:0] next_dataLow;
  logic [5:0] next_dataHigh;
  logic [7:0] next_addrLow;
  logic [6:0] next_addrHigh;
  logic next_cfgSel;
  logic [31:0] next_prdata;

  logic acc;
  logic wrAcc;
  logic rdCmd;
  logic wrCmd;
  logic [PADDR_W-1:0] wordAddr;
  logic [3:0] cfgIdx;
  logic cfgHigh;
  logic cfgMapped;
  logic cfgWritable;
  logic [WORD_W-1:0] readWord;
  logic [WORD_W-1:0] wrWord;

  assign acc = psel && penable;
  assign wrAcc = acc && pwrite && pstrb[0];
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign rdCmd = wrAcc && paddr == OFF_CONTROL && pwdata[CTRL_RD_BIT];
  assign wrCmd = wrAcc && paddr == OFF_CONTROL && pwdata[CTRL_WR_BIT];
  assign wordAddr = {addrHigh, addrLow};
  assign wrWord = {dataHigh, dataLow};
  assign ctlWr = wrAcc && paddr == OFF_CONTROL;
  assign effSel = ctlWr ? pwdata[CTRL_CONFIG_SPACE_SELECT_BIT] : cfgSel; // RULE2

  // ----------------------------------------
  // Config space decode
  // ----------------------------------------
  assign cfgIdx = wordAddr[3:0];
  assign cfgHigh = wordAddr[PADDR_W-1:4] == '0; // RULE3
  assign cfgMapped = cfgHigh && (cfgIdx <= USER_ID_LAST || // RULE5
    (cfgIdx >= DEV_ID_IDX && cfgIdx <= CFG_WORD_LAST));
  assign cfgWritable = cfgHigh && cfgIdx <= USER_ID_LAST; // RULE11

  always_comb begin
    readWord = ZERO_WORD; // RULE4
    if (effSel) begin // RULE2
      if (cfgMapped) begin
        if (cfgIdx <= USER_ID_LAST) begin
          readWord = userId[cfgIdx[1:0]];
        end else if (cfgIdx == DEV_ID_IDX) begin
          readWord = DEVICE_ID_WORD;
        end else if (cfgIdx == CFG_WORD_FIRST) begin
          readWord = CONFIG_WORD1;
        end else begin
          readWord = CONFIG_WORD2;
        end
      end
    end else begin
      readWord = progMem[wordAddr[10:0]];
    end
  end

  // ----------------------------------------
  // Register next values
  // ----------------------------------------
  always_comb begin
    next_dataLow = dataLow;
    next_dataHigh = dataHigh;
    next_addrLow = addrLow;
    next_addrHigh = addrHigh;
    next_cfgSel = cfgSel;
    if (wrAcc) begin
      unique case (paddr)
        OFF_DATA_LOW: next_dataLow = pwdata[7:0]; // RULE7
        OFF_DATA_HIGH: next_dataHigh = pwdata[DATA_HIGH_W-1:0]; // RULE8
        OFF_ADDR_LOW: next_addrLow = pwdata[7:0]; // RULE9
        OFF_ADDR_HIGH: next_addrHigh = pwdata[ADDR_HIGH_W-1:0]; // RULE10
        OFF_CONTROL: next_cfgSel = pwdata[CTRL_CONFIG_SPACE_SELECT_BIT];
        default: next_cfgSel = cfgSel;
      endcase
    end
    if (rdCmd) begin
      next_dataLow = readWord[7:0]; // RULE4
      next_dataHigh = readWord[WORD_W-1:8];
    end
    if (srst) begin
      next_addrLow = ADDR_LOW_RESET; // RULE9
      next_addrHigh = ADDR_HIGH_RESET;
      next_cfgSel = 1'b0;
    end
  end

  always_comb begin
    next_prdata = prdata;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        OFF_DATA_LOW: next_prdata = {24'h00_0000, dataLow};
        OFF_DATA_HIGH: next_prdata = {26'h000_0000, dataHigh}; // RULE8
        OFF_ADDR_LOW: next_prdata = {24'h00_0000, addrLow};
        OFF_ADDR_HIGH: next_prdata = {24'h00_0000, ADDR_HIGH_TOP, addrHigh}; // RULE10
        OFF_CONTROL: next_prdata = {25'h000_0000, cfgSel, 6'h00};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    dataLow <= next_dataLow;
    dataHigh <= next_dataHigh;
    addrLow <= next_addrLow;
    addrHigh <= next_addrHigh;
    cfgSel <= next_cfgSel;
    prdata <= srst ? 32'h0000_0000 : next_prdata;
  end

  // ----------------------------------------
  // Storage write
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (wrCmd) begin
      if (effSel) begin
        if (cfgWritable) begin // RULE11
          userId[cfgIdx[1:0]] <= wrWord;
        end
      end else begin
        progMem[wordAddr[10:0]] <= wrWord;
      end
    end
  end

  // ----------------------------------------
  // Checks: data registers
  // ----------------------------------------
  a_data_low_wr: assert property (@(posedge sys_clk) disable iff (srst) // RULE7
    wrAcc && paddr == OFF_DATA_LOW |=> dataLow == $past(pwdata[7:0]))
    else $error("data low write lost");

  a_data_high_wr: assert property (@(posedge sys_clk) disable iff (srst) // RULE8
    wrAcc && paddr == OFF_DATA_HIGH |=> dataHigh == $past(pwdata[DATA_HIGH_W-1:0]))
    else $error("data high write lost");

  a_data_low_hold: assert property (@(posedge sys_clk) // RULE7
    srst && !wrAcc |=> $stable(dataLow))
    else $error("data low changed by reset");

  a_data_keep: assert property (@(posedge sys_clk) disable iff (srst) // RULE7
    !wrAcc |=> $stable(dataLow) && $stable(dataHigh))
    else $error("data registers changed without write");

  a_data_low_read: assert property (@(posedge sys_clk) disable iff (srst) // RULE7
    psel && !penable && !pwrite && paddr == OFF_DATA_LOW |=> prdata == {24'h00_0000, $past(dataLow)})
    else $error("data low read wrong");

  a_data_high_zero: assert property (@(posedge sys_clk) disable iff (srst) // RULE8
    psel && !penable && !pwrite && paddr == OFF_DATA_HIGH |=> prdata[7:6] == 2'b00)
    else $error("data high top bits not zero");

  a_data_high_read: assert property (@(posedge sys_clk) disable iff (srst) // RULE8
    psel && !penable && !pwrite && paddr == OFF_DATA_HIGH |=> prdata[5:0] == $past(dataHigh))
    else $error("data high read wrong");

  // ----------------------------------------
  // Checks: address registers
  // ----------------------------------------
  a_addr_reset: assert property (@(posedge sys_clk) // RULE9
    srst |=> addrLow == 8'h00 && addrHigh == 7'h00)
    else $error("address not reset");

  a_addr_low_wr: assert property (@(posedge sys_clk) disable iff (srst) // RULE9
    wrAcc && paddr == OFF_ADDR_LOW |=> addrLow == $past(pwdata[7:0]))
    else $error("address low write lost");

  a_addr_high_wr: assert property (@(posedge sys_clk) disable iff (srst) // RULE10
    wrAcc && paddr == OFF_ADDR_HIGH |=> addrHigh == $past(pwdata[ADDR_HIGH_W-1:0]))
    else $error("address high write lost");

  a_addr_keep: assert property (@(posedge sys_clk) disable iff (srst) // RULE9
    !wrAcc |=> $stable(addrLow) && $stable(addrHigh))
    else $error("address changed without write");

  a_addr_low_read: assert property (@(posedge sys_clk) disable iff (srst) // RULE9
    psel && !penable && !pwrite && paddr == OFF_ADDR_LOW |=> prdata == {24'h00_0000, $past(addrLow)})
    else $error("address low read wrong");

  a_high_read_one: assert property (@(posedge sys_clk) disable iff (srst) // RULE10
    psel && !penable && !pwrite && paddr == OFF_ADDR_HIGH |=> prdata[7] && prdata[6:0] == addrHigh)
    else $error("address high top bit not one");

  // ----------------------------------------
  // Checks: config space
  // ----------------------------------------
  a_sel_write: assert property (@(posedge sys_clk) disable iff (srst) // RULE2
    ctlWr |=> cfgSel == $past(pwdata[CTRL_CONFIG_SPACE_SELECT_BIT]))
    else $error("config select write lost");

  a_sel_reset: assert property (@(posedge sys_clk) // RULE2
    srst |=> !cfgSel)
    else $error("config select not reset");

  a_sel_keep: assert property (@(posedge sys_clk) disable iff (srst) // RULE2
    !ctlWr |=> $stable(cfgSel))
    else $error("config select changed without write");

  a_ctrl_read: assert property (@(posedge sys_clk) disable iff (srst) // RULE2
    psel && !penable && !pwrite && paddr == OFF_CONTROL |=>
    prdata == {25'h000_0000, $past(cfgSel), 6'h00})
    else $error("control read wrong");

  a_unmapped_clear: assert property (@(posedge sys_clk) disable iff (srst) // RULE4
    rdCmd && effSel && !cfgMapped |=> dataLow == 8'h00 && dataHigh == 6'h00)
    else $error("unmapped config read did not clear data");

  a_cfg_half: assert property (@(posedge sys_clk) disable iff (srst) // RULE3
    rdCmd && effSel && !cfgHigh |=> {dataHigh, dataLow} == ZERO_WORD)
    else $error("config read outside region not zero");

  a_devid_read: assert property (@(posedge sys_clk) disable iff (srst) // RULE5
    rdCmd && effSel && cfgHigh && cfgIdx == DEV_ID_IDX |=>
    {dataHigh, dataLow} == DEVICE_ID_WORD)
    else $error("device id read wrong");

  a_cfg_redirect: assert property (@(posedge sys_clk) disable iff (srst) // RULE2
    rdCmd && effSel && cfgIdx == CFG_WORD_FIRST && cfgHigh |=>
    {dataHigh, dataLow} == CONFIG_WORD1)
    else $error("config word read wrong");

  a_cfg_word2: assert property (@(posedge sys_clk) disable iff (srst) // RULE5
    rdCmd && effSel && cfgIdx == CFG_WORD_LAST && cfgHigh |=>
    {dataHigh, dataLow} == CONFIG_WORD2)
    else $error("second config word read wrong");

  a_user_id_read: assert property (@(posedge sys_clk) disable iff (srst) // RULE5
    rdCmd && !wrCmd && effSel && cfgWritable |=>
    {dataHigh, dataLow} == userId[$past(cfgIdx[1:0])])
    else $error("user id read wrong");

  a_prog_read: assert property (@(posedge sys_clk) disable iff (srst) // RULE2
    rdCmd && !wrCmd && !effSel |=>
    {dataHigh, dataLow} == progMem[$past(wordAddr[10:0])])
    else $error("program word read wrong");

  // ----------------------------------------
  // Checks: storage writes
  // ----------------------------------------
  a_user_id_write: assert property (@(posedge sys_clk) disable iff (srst) // RULE5
    wrCmd && effSel && cfgWritable |=> userId[$past(cfgIdx[1:0])] == $past(wrWord))
    else $error("user id write lost");

  a_prog_write: assert property (@(posedge sys_clk) disable iff (srst) // RULE2
    wrCmd && !effSel |=> progMem[$past(wordAddr[10:0])] == $past(wrWord))
    else $error("program word write lost");

  a_ro_kept: assert property (@(posedge sys_clk) disable iff (srst) // RULE11
    wrCmd && effSel && !cfgWritable |=> !$changed(userId[0]))
    else $error("read-only write altered storage");

  // ----------------------------------------
  // Checks: bus response
  // ----------------------------------------
  a_ready_high: assert property (@(posedge sys_clk) disable iff (srst)
    psel && penable |-> pready)
    else $error("access phase not ready");

  a_no_error: assert property (@(posedge sys_clk) disable iff (srst)
    psel && penable |-> !pslverr)
    else $error("unexpected slave error");

  a_prdata_hold: assert property (@(posedge sys_clk) disable iff (srst)
    !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside setup");
endmodule

// ==== tb/tb_flash_self_access.sv ====
// Testbench for the flash self-access register block
`timescale 1ns/1ps
module tb_flash_self_access;
  import flash_self_access_pkg::*;
  localparam logic [13:0] DEV_ID = 14'h0A5C; // Arbitrary value
  localparam logic [13:0] CW1 = 14'h2AAA;
  localparam logic [13:0] CW2 = 14'h1555;
  logic sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr;
  logic [13:0] exp3 [3] = '{DEV_ID, CW1, CW2};
  logic [13:0] ram [2];
  logic [13:0] expRow [2] = '{14'h0123, 14'h2BCD};
  int mismatches = 0, checks_done = 0;
  flash_self_access #(.DEVICE_ID_WORD(DEV_ID), .CONFIG_WORD1(CW1), .CONFIG_WORD2(CW2)) uut (
    .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // ----------------------------------------
  // Clock, bus tasks, checks
  // ----------------------------------------
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    checks_done++;
    if (q !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, q);
    end
  endtask
  task automatic op(input logic [6:0] ah, input logic [7:0] al, input logic [13:0] d,
                    input logic [7:0] ctl);
    apb(1'b1, OFF_ADDR_HIGH, {25'h0, ah});
    apb(1'b1, OFF_ADDR_LOW, {24'h0, al});
    apb(1'b1, OFF_DATA_LOW, {24'h0, d[7:0]});
    apb(1'b1, OFF_DATA_HIGH, {26'h0, d[13:8]});
    apb(1'b1, OFF_CONTROL, {24'h0, ctl});
  endtask
  task automatic word(input string n, input logic [13:0] e);
    rchk(n, OFF_DATA_LOW, {24'h0, e[7:0]});
    rchk(n, OFF_DATA_HIGH, {26'h0, e[13:8]});
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    close_out();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    rchk("addr_low", OFF_ADDR_LOW, 32'h0);
    rchk("addr_high", OFF_ADDR_HIGH, 32'h80);
    rchk("unmapped", 8'h14, 32'h0);
    $display("Test reset values done");
    apb(1'b1, OFF_DATA_LOW, 32'hFF);
    apb(1'b1, OFF_DATA_HIGH, 32'hFF);
    apb(1'b1, OFF_ADDR_LOW, 32'h5A);
    rchk("data_high", OFF_DATA_HIGH, 32'h3F);
    srst <= 1'b1;
    @(posedge sys_clk);
    srst <= 1'b0;
    rchk("data_low", OFF_DATA_LOW, 32'hFF);
    rchk("addr_low", OFF_ADDR_LOW, 32'h0);
    $display("Test data registers done");
    op(7'h00, 8'h02, 14'h1111, 8'h02);
    op(7'h00, 8'h02, 14'h2222, 8'h42);
    op(7'h00, 8'h02, 14'h3C3C, 8'h01);
    word("prog_word", 14'h1111);
    op(7'h00, 8'h02, 14'h3C3C, 8'h41);
    word("user_id", 14'h2222);
    rchk("control", OFF_CONTROL, 32'h40);
    $display("Test config select done");
    for (int i = 0; i < 3; i++) begin
      op(7'h00, 8'(6 + i), 14'h0000, 8'h42);
      op(7'h00, 8'(6 + i), 14'h3C3C, 8'h41);
      word("read_only", exp3[i]);
    end
    $display("Test read-only entries done");
    foreach (exp3[i]) begin
      op(7'h00, 8'(4 + i * 5), 14'h3C3C, 8'h41);
      word("unmapped_cfg", 14'h0000);
    end
    op(7'h01, 8'h00, 14'h3C3C, 8'h41);
    word("high_half", 14'h0000);
    $display("Test unmapped config reads done");
    op(7'h00, 8'h10, 14'h0123, 8'h02);
    op(7'h00, 8'h11, 14'h0456, 8'h02);
    for (int i = 0; i < 2; i++) begin
      op(7'h00, 8'(16 + i), 14'h0000, 8'h01);
      apb(1'b0, OFF_DATA_LOW, 32'h0);
      ram[i][7:0] = q[7:0];
      apb(1'b0, OFF_DATA_HIGH, 32'h0);
      ram[i][13:8] = q[5:0];
    end
    ram[1] = 14'h2BCD;
    for (int i = 0; i < 2; i++) begin
      op(7'h00, 8'(16 + i), ram[i], 8'h02);
    end
    for (int i = 0; i < 2; i++) begin
      op(7'h00, 8'(16 + i), 14'h0000, 8'h01);
      word("row_verify", expRow[i]);
    end
    $display("Test row modify done");
    close_out();
  end
endmodule
